/* src/gpio_function_mux.sv */
`timescale 1ns/1ps

// What this block does
// - Selector bits 3-0; code 0000 drives low
// - Selector registers reset to 0x00
// - Code 0010 drives software output value bit
// - Code 0011 drives both-channels auto-mute flag
// - Codes 0100/0101 drive left/right auto-mute
// - Code 0110 drives clock-invalid flag
// - Code 1000 drives warning indication
// - Code 1001 drives serial audio data out
// - Code 1011 drives fault indication
// - Codes 1100/1101 drive SPI clock/MOSI
// - MISO and phase-sync source fields route pins
// - Reset source field routes pin; no self-clear
// - Mute source low puts output stage high-impedance
// - Output value bits 2-0 per pin
// - Invert bits 2-0 invert pin levels
// - Read-only die identification at index 67h
// - Pin driven only while direction bit set
module gpio_function_mux (
	input  wire logic                                  clk,
	input  wire logic                                  resetn,
	input  wire logic [gpio_mux_pkg::ADDR_W-1:0]       s_axi_awaddr,
	input  wire logic                                  s_axi_awvalid,
	output logic                                       s_axi_awready,
	input  wire logic [31:0]                           s_axi_wdata,
	input  wire logic [3:0]                            s_axi_wstrb,
	input  wire logic                                  s_axi_wvalid,
	output logic                                       s_axi_wready,
	output logic [1:0]                                 s_axi_bresp,
	output logic                                       s_axi_bvalid,
	input  wire logic                                  s_axi_bready,
	input  wire logic [gpio_mux_pkg::ADDR_W-1:0]       s_axi_araddr,
	input  wire logic                                  s_axi_arvalid,
	output logic                                       s_axi_arready,
	output logic [31:0]                                s_axi_rdata,
	output logic [1:0]                                 s_axi_rresp,
	output logic                                       s_axi_rvalid,
	input  wire logic                                  s_axi_rready,
	input  wire gpio_mux_pkg::core_flags_t             flags,
	input  wire logic [gpio_mux_pkg::PIN_COUNT-1:0]    pin_in,
	output logic [gpio_mux_pkg::PIN_COUNT-1:0]         pin_out,
	output logic [gpio_mux_pkg::PIN_COUNT-1:0]         pin_oe,
	output gpio_mux_pkg::routed_inputs_t               routed,
	output logic                                       irq
);

	localparam int NP = gpio_mux_pkg::PIN_COUNT;

	gpio_mux_pkg::regs_t          regs;
	gpio_mux_pkg::regs_t          next_regs;
	logic [gpio_mux_pkg::ADDR_W-1:0] aw_addr;
	logic [gpio_mux_pkg::ADDR_W-1:0] next_aw_addr;
	logic                         aw_held;
	logic                         next_aw_held;
	logic [7:0]                   w_data;
	logic [7:0]                   next_w_data;
	logic                         w_lane0;
	logic                         next_w_lane0;
	logic                         w_held;
	logic                         next_w_held;
	logic                         bvalid;
	logic                         next_bvalid;
	logic [1:0]                   bresp;
	logic [1:0]                   next_bresp;
	logic                         rvalid;
	logic                         next_rvalid;
	logic [7:0]                   rdata;
	logic [7:0]                   next_rdata;
	logic [1:0]                   rresp;
	logic [1:0]                   next_rresp;
	logic [NP-1:0]                next_pin_out;
	logic [NP-1:0]                next_pin_oe;
	gpio_mux_pkg::routed_inputs_t next_routed;
	logic [gpio_mux_pkg::EV_COUNT-1:0] ev_level;
	logic [gpio_mux_pkg::EV_COUNT-1:0] ev_prev;
	logic [gpio_mux_pkg::EV_COUNT-1:0] ev_pulse;

	function automatic logic [7:0] byte_index(input logic [gpio_mux_pkg::ADDR_W-1:0] a);
		return a[gpio_mux_pkg::ADDR_W-3:2];
	endfunction

	function automatic logic mapped(input logic [gpio_mux_pkg::ADDR_W-1:0] a);
		logic [7:0] idx;
		idx = byte_index(a);
		return (a[1:0] == 2'h0) &&
			(((idx >= gpio_mux_pkg::IDX_DIR) && (idx <= gpio_mux_pkg::IDX_DIE)) ||
			(idx == gpio_mux_pkg::IDX_STATUS) || (idx == gpio_mux_pkg::IDX_MASK));
	endfunction

	// Pick a pin by a two-bit source field; zero selects no pin
	function automatic logic route_pick(input logic [1:0] src, input logic [NP-1:0] pins,
			input logic idle);
		logic r;
		r = idle;
		unique case (src)
			2'h0: r = idle;
			2'h1: r = pins[0];
			2'h2: r = pins[1];
			2'h3: r = pins[2];
		endcase
		return r;
	endfunction

	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready  = !w_held && !bvalid;
	assign s_axi_arready = !rvalid;
	assign s_axi_bvalid  = bvalid;
	assign s_axi_bresp   = bresp;
	assign s_axi_rvalid  = rvalid;
	assign s_axi_rresp   = rresp;
	assign s_axi_rdata   = {24'h000000, rdata};
	assign irq           = |(regs.status & regs.mask);

	// Event sources for the sticky status bits
	assign ev_level = {!routed.mute_in_n, !flags.fault_out_n, !flags.warning_out_n,
		flags.clock_invalid};
	assign ev_pulse = ev_level & ~ev_prev;

	always_comb begin
		logic [7:0] idx;
		logic       rd_take;
		logic       rd_status;
		idx          = 8'h00;
		rd_take      = s_axi_arvalid && !rvalid;
		rd_status    = 1'b0;
		next_regs    = regs;
		next_aw_addr = aw_addr;
		next_aw_held = aw_held;
		next_w_data  = w_data;
		next_w_lane0 = w_lane0;
		next_w_held  = w_held;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;

		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_addr = s_axi_awaddr;
			next_aw_held = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_data  = s_axi_wdata[7:0];
			next_w_lane0 = s_axi_wstrb[0];
			next_w_held  = 1'b1;
		end
		if (aw_held && w_held) begin
			idx         = byte_index(aw_addr);
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = gpio_mux_pkg::RESP_OKAY;
			if (!mapped(aw_addr) || (idx == gpio_mux_pkg::IDX_DIE)) begin
				next_bresp = gpio_mux_pkg::RESP_SLVERR;
			end else if (w_lane0) begin
				unique case (idx)
					gpio_mux_pkg::IDX_DIR:    next_regs.dir = w_data;
					gpio_mux_pkg::IDX_SEL0:   next_regs.sel[0] = w_data;
					gpio_mux_pkg::IDX_SEL1:   next_regs.sel[1] = w_data;
					gpio_mux_pkg::IDX_SEL2:   next_regs.sel[2] = w_data;
					gpio_mux_pkg::IDX_ROUTE:  next_regs.route = w_data;
					gpio_mux_pkg::IDX_OUT:    next_regs.out = w_data;
					gpio_mux_pkg::IDX_INV:    next_regs.inv = w_data;
					gpio_mux_pkg::IDX_MASK:
						next_regs.mask = w_data[gpio_mux_pkg::EV_COUNT-1:0];
					default:                  next_regs.dir = regs.dir;
				endcase
			end
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end

		if (rd_take) begin
			idx         = byte_index(s_axi_araddr);
			next_rvalid = 1'b1;
			next_rresp  = gpio_mux_pkg::RESP_OKAY;
			next_rdata  = 8'h00;
			if (!mapped(s_axi_araddr)) begin
				next_rresp = gpio_mux_pkg::RESP_SLVERR;
			end else begin
				unique case (idx)
					gpio_mux_pkg::IDX_DIR:    next_rdata = regs.dir;
					gpio_mux_pkg::IDX_SEL0:   next_rdata = regs.sel[0];
					gpio_mux_pkg::IDX_SEL1:   next_rdata = regs.sel[1];
					gpio_mux_pkg::IDX_SEL2:   next_rdata = regs.sel[2];
					gpio_mux_pkg::IDX_ROUTE:  next_rdata = regs.route;
					gpio_mux_pkg::IDX_OUT:    next_rdata = regs.out;
					gpio_mux_pkg::IDX_INV:    next_rdata = regs.inv;
					gpio_mux_pkg::IDX_DIE:    next_rdata = gpio_mux_pkg::DIE_IDENT_VALUE;
					gpio_mux_pkg::IDX_STATUS: begin
						next_rdata = {4'h0, regs.status};
						rd_status  = 1'b1;
					end
					gpio_mux_pkg::IDX_MASK:   next_rdata = {4'h0, regs.mask};
					default:                  next_rdata = 8'h00;
				endcase
			end
		end
		if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end

		// Read clears status; a new event in the same cycle wins
		next_regs.status = (rd_status ? '0 : regs.status) | ev_pulse;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			regs    <= '{dir: gpio_mux_pkg::REG_RESET,
				sel: {NP{gpio_mux_pkg::REG_RESET}},
				route: gpio_mux_pkg::REG_RESET, out: gpio_mux_pkg::REG_RESET,
				inv: gpio_mux_pkg::REG_RESET, status: '0, mask: '0};
			aw_addr <= '0;
			aw_held <= 1'b0;
			w_data  <= 8'h00;
			w_lane0 <= 1'b0;
			w_held  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= 2'h0;
			rvalid  <= 1'b0;
			rdata   <= 8'h00;
			rresp   <= 2'h0;
			ev_prev <= '0;
		end else begin
			regs    <= next_regs;
			aw_addr <= next_aw_addr;
			aw_held <= next_aw_held;
			w_data  <= next_w_data;
			w_lane0 <= next_w_lane0;
			w_held  <= next_w_held;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
			ev_prev <= ev_level;
		end
	end

	// Pin output multiplexer, one per pin
	always_comb begin
		logic mux;
		mux = 1'b0;
		for (int i = 0; i < NP; i++) begin
			unique case (regs.sel[i][3:0])
				gpio_mux_pkg::FN_VALUE:       mux = regs.out[i];
				gpio_mux_pkg::FN_MUTE_BOTH:
					mux = flags.auto_mute_left && flags.auto_mute_right;
				gpio_mux_pkg::FN_MUTE_LEFT:   mux = flags.auto_mute_left;
				gpio_mux_pkg::FN_MUTE_RIGHT:  mux = flags.auto_mute_right;
				gpio_mux_pkg::FN_CLK_INVALID: mux = flags.clock_invalid;
				gpio_mux_pkg::FN_WARNING:     mux = flags.warning_out_n;
				gpio_mux_pkg::FN_SERIAL_OUT:  mux = flags.serial_audio_data_out;
				gpio_mux_pkg::FN_FAULT:       mux = flags.fault_out_n;
				gpio_mux_pkg::FN_SPI_CLK:     mux = flags.spi_clk;
				gpio_mux_pkg::FN_SPI_MOSI:    mux = flags.spi_mosi;
				default:                      mux = 1'b0;
			endcase
			next_pin_out[i] = mux ^ regs.inv[i];
			next_pin_oe[i]  = regs.dir[i];
		end
	end

	// Input routing
	always_comb begin
		next_routed.spi_miso = route_pick(
			regs.route[gpio_mux_pkg::ROUTE_MISO_LSB +: 2], pin_in, 1'b0);
		next_routed.phase_sync = route_pick(
			regs.route[gpio_mux_pkg::ROUTE_SYNC_LSB +: 2], pin_in, 1'b0);
		next_routed.ext_reset_n = route_pick(
			regs.route[gpio_mux_pkg::ROUTE_RESET_LSB +: 2], pin_in, 1'b1);
		next_routed.mute_in_n = route_pick(
			regs.route[gpio_mux_pkg::ROUTE_MUTE_LSB +: 2], pin_in, 1'b1);
		next_routed.output_stage_hiz = !next_routed.mute_in_n;
	end

	// Only resetn clears this logic, never the routed reset pin
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_out <= '0;
			pin_oe  <= '0;
			routed  <= '{spi_miso: 1'b0, phase_sync: 1'b0, ext_reset_n: 1'b1,
				mute_in_n: 1'b1, output_stage_hiz: 1'b0};
		end else begin
			pin_out <= next_pin_out;
			pin_oe  <= next_pin_oe;
			routed  <= next_routed;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	for (genvar g = 0; g < NP; g++) begin : g_chk
		low_code_a: assert property (
			(regs.sel[g][3:0] inside {4'h0, 4'h1, 4'h7, 4'hA, 4'hE, 4'hF})
				|=> (pin_out[g] == $past(regs.inv[g])))
			else $error("low code did not drive low level");
		value_code_a: assert property (
			(regs.sel[g][3:0] == gpio_mux_pkg::FN_VALUE)
				|=> (pin_out[g] == ($past(regs.out[g]) ^ $past(regs.inv[g]))))
			else $error("value code mismatch");
		dir_gate_a: assert property (
			!regs.dir[g] |=> !pin_oe[g])
			else $error("pin driven while input");
		spi_clk_a: assert property (
			(regs.sel[g][3:0] == gpio_mux_pkg::FN_SPI_CLK)
				|=> (pin_out[g] == ($past(flags.spi_clk) ^ $past(regs.inv[g]))))
			else $error("spi clock not routed");
	end

	sel_reset_a: assert property (
		$rose(resetn) |-> (regs.sel == '0) && (pin_out == '0))
		else $error("selectors not zero after reset");
	mute_both_a: assert property (
		(regs.sel[0][3:0] == gpio_mux_pkg::FN_MUTE_BOTH) && !regs.inv[0]
			|=> (pin_out[0] == ($past(flags.auto_mute_left) && $past(flags.auto_mute_right))))
		else $error("combined mute flag wrong");
	miso_route_a: assert property (
		(regs.route[7:6] == 2'h2) |=> (routed.spi_miso == $past(pin_in[1])))
		else $error("miso routing wrong");
	mute_hiz_a: assert property (
		(regs.route[1:0] == 2'h1) && !pin_in[0] |=> routed.output_stage_hiz)
		else $error("mute pin did not stop output stage");
	die_read_a: assert property (
		s_axi_arvalid && s_axi_arready && (s_axi_araddr == {2'h0, gpio_mux_pkg::IDX_DIE, 2'h0})
			|=> s_axi_rvalid && (s_axi_rdata == {24'h000000, gpio_mux_pkg::DIE_IDENT_VALUE}))
		else $error("die_identification read wrong");
	write_resp_a: assert property (
		aw_held && w_held |=> s_axi_bvalid)
		else $error("write response missing");

	serial_out_cov: cover property (
		regs.dir[0] && (regs.sel[0][3:0] == gpio_mux_pkg::FN_SERIAL_OUT));
	status_read_cov: cover property (
		s_axi_rvalid && (s_axi_rdata[3:0] != 4'h0));
	irq_cov: cover property ($rose(irq));
	hiz_cov: cover property ($rose(routed.output_stage_hiz));

endmodule

/* src/gpio_mux_pkg.sv */
package gpio_mux_pkg;

	localparam int          PIN_COUNT = 3;
	localparam int          ADDR_W    = 12;
	localparam int          EV_COUNT  = 4;

	// Register indices; the byte address is four times the index
	localparam logic [7:0]  IDX_DIR     = 8'h60;
	localparam logic [7:0]  IDX_SEL0    = 8'h61;
	localparam logic [7:0]  IDX_SEL1    = 8'h62;
	localparam logic [7:0]  IDX_SEL2    = 8'h63;
	localparam logic [7:0]  IDX_ROUTE   = 8'h64;
	localparam logic [7:0]  IDX_OUT     = 8'h65;
	localparam logic [7:0]  IDX_INV     = 8'h66;
	localparam logic [7:0]  IDX_DIE     = 8'h67;
	localparam logic [7:0]  IDX_STATUS  = 8'h70;
	localparam logic [7:0]  IDX_MASK    = 8'h71;

	localparam logic [7:0]  REG_RESET   = 8'h00;
	// Identification value is arbitrary
	localparam logic [7:0]  DIE_IDENT_VALUE = 8'h5A;

	// Function codes of a pin selector
	localparam logic [3:0]  FN_LOW         = 4'h0;
	localparam logic [3:0]  FN_VALUE       = 4'h2;
	localparam logic [3:0]  FN_MUTE_BOTH   = 4'h3;
	localparam logic [3:0]  FN_MUTE_LEFT   = 4'h4;
	localparam logic [3:0]  FN_MUTE_RIGHT  = 4'h5;
	localparam logic [3:0]  FN_CLK_INVALID = 4'h6;
	localparam logic [3:0]  FN_WARNING     = 4'h8;
	localparam logic [3:0]  FN_SERIAL_OUT  = 4'h9;
	localparam logic [3:0]  FN_FAULT       = 4'hB;
	localparam logic [3:0]  FN_SPI_CLK     = 4'hC;
	localparam logic [3:0]  FN_SPI_MOSI    = 4'hD;

	// Field positions of the input routing register
	localparam int          ROUTE_MISO_LSB  = 6;
	localparam int          ROUTE_SYNC_LSB  = 4;
	localparam int          ROUTE_RESET_LSB = 2;
	localparam int          ROUTE_MUTE_LSB  = 0;

	// Event bit positions of status and mask
	localparam int          EV_CLK_INVALID = 0;
	localparam int          EV_WARNING     = 1;
	localparam int          EV_FAULT       = 2;
	localparam int          EV_MUTE        = 3;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic auto_mute_left;
		logic auto_mute_right;
		logic clock_invalid;
		logic warning_out_n;
		logic fault_out_n;
		logic serial_audio_data_out;
		logic spi_clk;
		logic spi_mosi;
	} core_flags_t;

	typedef struct packed {
		logic spi_miso;
		logic phase_sync;
		logic ext_reset_n;
		logic mute_in_n;
		logic output_stage_hiz;
	} routed_inputs_t;

	typedef struct packed {
		logic [7:0]                 dir;
		logic [PIN_COUNT-1:0][7:0]  sel;
		logic [7:0]                 route;
		logic [7:0]                 out;
		logic [7:0]                 inv;
		logic [EV_COUNT-1:0]        status;
		logic [EV_COUNT-1:0]        mask;
	} regs_t;

endpackage

/* test/pin_peer_model.sv */
`timescale 1ns/1ps

// Board peer on the three pins; it drives a line only while the block lets go of it
module pin_peer_model (
	input  wire logic [2:0] pin_out,
	input  wire logic [2:0] pin_oe,
	input  wire logic [2:0] peer_level,
	output logic      [2:0] pin_in
);
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : peer_level[i];
		end
	end
endmodule

/* test/gpio_function_mux_tb.sv */
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value %s exp %0h got %0h", nm, e, g); end end

module gpio_function_mux_tb;
	logic                          clk = 0, resetn = 0, pin_chk = 0;
	logic [11:0]                   s_axi_awaddr = '0, s_axi_araddr = '0;
	logic                          s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic                          s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0]                   s_axi_wdata = '0;
	logic [3:0]                    s_axi_wstrb = 4'hF;
	logic                          s_axi_awready, s_axi_wready, s_axi_bvalid, irq;
	logic                          s_axi_arready, s_axi_rvalid;
	logic [1:0]                    s_axi_bresp, s_axi_rresp, be;
	logic [31:0]                   s_axi_rdata;
	gpio_mux_pkg::core_flags_t     flags = 8'h18;
	gpio_mux_pkg::routed_inputs_t  routed;
	logic [2:0]                    pin_in, pin_out, pin_oe, peer_level = 3'h7;
	int                            num_errors = 0, check_count = 0;
	logic [11:0]                   pq[$], pe;
	logic [10:0]                   rq[$], re;
	logic [1:0]                    bq[$];

	always #25 clk = ~clk;

	gpio_function_mux dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flags, .pin_in, .pin_out, .pin_oe,
		.routed, .irq);

	pin_peer_model peer (.pin_out, .pin_oe, .peer_level, .pin_in);

	task automatic print_verdict;
		if (num_errors == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic a, w, ra, rw, b;
		a = 0;
		w = 0;
		b = 0;
		bq.push_back(er);
		s_axi_awaddr <= {2'h0, idx, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(a && w)) begin
			@(negedge clk);
			ra = s_axi_awready;
			rw = s_axi_wready;
			@(posedge clk);
			if (ra && !a) begin
				a = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (rw && !w) begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!b) begin
			@(negedge clk);
			b = s_axi_bvalid;
			@(posedge clk);
		end
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic r;
		r = 0;
		rq.push_back({er == 2'h0, er, d});
		s_axi_araddr <= {2'h0, idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r) begin
			@(negedge clk);
			r = s_axi_arready;
			@(posedge clk);
		end
		s_axi_arvalid <= 1'b0;
		r = 0;
		while (!r) begin
			@(negedge clk);
			r = s_axi_rvalid;
			@(posedge clk);
		end
	endtask

	// Lets register and flag changes reach the registered pin outputs first
	task automatic pins(input logic [11:0] e);
		repeat (3) @(posedge clk);
		pq.push_back(e);
		pin_chk <= 1'b1;
		@(posedge clk);
		pin_chk <= 1'b0;
	endtask

	function automatic logic [2:0] mux_exp(logic [11:0] cd, gpio_mux_pkg::core_flags_t f,
			logic [2:0] o, logic [2:0] v);
		logic [2:0] p;
		for (int i = 0; i < 3; i++) begin
			case (cd[4*i +: 4])
				4'h2:    p[i] = o[i];
				4'h3:    p[i] = f.auto_mute_left & f.auto_mute_right;
				4'h4:    p[i] = f.auto_mute_left;
				4'h5:    p[i] = f.auto_mute_right;
				4'h6:    p[i] = f.clock_invalid;
				4'h8:    p[i] = f.warning_out_n;
				4'h9:    p[i] = f.serial_audio_data_out;
				4'hB:    p[i] = f.fault_out_n;
				4'hC:    p[i] = f.spi_clk;
				4'hD:    p[i] = f.spi_mosi;
				default: p[i] = 1'b0;
			endcase
		end
		return p ^ v;
	endfunction

	always @(posedge clk) begin
		if (pin_chk) begin
			pe = pq.pop_front();
			`CHECK("pins", pe, {irq, routed, pin_oe, pin_out})
		end
		if (s_axi_bvalid && s_axi_bready) begin
			be = bq.pop_front();
			`CHECK("bresp", be, s_axi_bresp)
		end
		if (s_axi_rvalid && s_axi_rready) begin
			re = rq.pop_front();
			`CHECK("rresp", re[9:8], s_axi_rresp)
			if (re[10]) `CHECK("rdata", {24'h0, re[7:0]}, s_axi_rdata)
		end
	end

	initial begin
		#(50 * 40000);
		num_errors++;
		print_verdict();
	end

	initial begin
		logic [31:0]               rv;
		logic [11:0]               cd;
		logic [7:0]                o, v;
		logic [1:0]                fb;
		logic                      rn, sl;
		gpio_mux_pkg::core_flags_t fl;
		void'($urandom(32'h382A9CE3));
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 7; i++) rd(8'h60 + 8'(i), 8'h00, 2'h0);
		rd(gpio_mux_pkg::IDX_DIE, gpio_mux_pkg::DIE_IDENT_VALUE, 2'h0);
		wr(gpio_mux_pkg::IDX_DIE, 8'hFF, gpio_mux_pkg::RESP_SLVERR);
		rd(gpio_mux_pkg::IDX_DIE, gpio_mux_pkg::DIE_IDENT_VALUE, 2'h0);
		rd(8'h7F, 8'h00, gpio_mux_pkg::RESP_SLVERR);
		// Unmasked clock-invalid event, then the same event masked
		wr(gpio_mux_pkg::IDX_MASK, 8'h01, 2'h0);
		flags.clock_invalid <= 1'b1;
		pins({1'b1, 5'b00110, 6'h00});
		rd(gpio_mux_pkg::IDX_STATUS, 8'h01, 2'h0);
		pins({1'b0, 5'b00110, 6'h00});
		flags.clock_invalid <= 1'b0;
		wr(gpio_mux_pkg::IDX_MASK, 8'h00, 2'h0);
		flags.clock_invalid <= 1'b1;
		pins({1'b0, 5'b00110, 6'h00});
		rd(gpio_mux_pkg::IDX_STATUS, 8'h01, 2'h0);
		wr(gpio_mux_pkg::IDX_DIR, 8'h07, 2'h0);
		// Every selector code on each pin, random flags, value and invert
		for (int c = 0; c < 16; c++) begin
			rv = $urandom;
			cd = {4'(c + 11), 4'(c + 5), 4'(c)};
			fl = gpio_mux_pkg::core_flags_t'(rv[7:0]);
			o = rv[15:8];
			v = rv[23:16];
			flags <= fl;
			wr(gpio_mux_pkg::IDX_SEL0, {rv[27:24], cd[3:0]}, 2'h0);
			wr(gpio_mux_pkg::IDX_SEL1, {4'h0, cd[7:4]}, 2'h0);
			wr(gpio_mux_pkg::IDX_SEL2, {4'h0, cd[11:8]}, 2'h0);
			wr(gpio_mux_pkg::IDX_OUT, o, 2'h0);
			wr(gpio_mux_pkg::IDX_INV, v, 2'h0);
			rd(gpio_mux_pkg::IDX_SEL0, {rv[27:24], cd[3:0]}, 2'h0);
			rd(gpio_mux_pkg::IDX_INV, v, 2'h0);
			pins({1'b0, 5'b00110, 3'h7, mux_exp(cd, fl, o[2:0], v[2:0])});
		end
		wr(gpio_mux_pkg::IDX_DIR, 8'h05, 2'h0);
		pins({1'b0, 5'b00110, 3'h5, mux_exp(cd, fl, o[2:0], v[2:0])});
		wr(gpio_mux_pkg::IDX_DIR, 8'h00, 2'h0);
		wr(gpio_mux_pkg::IDX_INV, 8'h00, 2'h0);
		// Same source field in all four input routes
		for (int f = 0; f < 4; f++) begin
			rv = $urandom;
			fb = 2'(f);
			sl = (f == 0) ? 1'b0 : rv[f - 1];
			rn = (f == 0) ? 1'b1 : rv[f - 1];
			peer_level <= rv[2:0];
			wr(gpio_mux_pkg::IDX_ROUTE, {fb, fb, fb, fb}, 2'h0);
			pins({1'b0, sl, sl, rn, rn, !rn, 3'h0, mux_exp(cd, fl, o[2:0], 3'h0)});
		end
		peer_level <= 3'h0;
		pins({1'b0, 5'b00001, 3'h0, mux_exp(cd, fl, o[2:0], 3'h0)});
		rd(gpio_mux_pkg::IDX_ROUTE, 8'hFF, 2'h0);
		rd(gpio_mux_pkg::IDX_OUT, o, 2'h0);
		// Lane 0 strobe low stores nothing
		s_axi_wstrb <= 4'hE;
		wr(gpio_mux_pkg::IDX_OUT, ~o, 2'h0);
		s_axi_wstrb <= 4'hF;
		rd(gpio_mux_pkg::IDX_OUT, o, 2'h0);
		// Let the last response reach the monitor
		repeat (2) @(posedge clk);
		print_verdict();
	end
endmodule
